//--- include/prc_pkg.sv
// Package for the port R pin control block: register map, reset values, timing.
// Assumes a 32-bit AXI4-Lite slave with byte addresses in a small local window.
package prc_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int PRC_ADDR_W = 12;
    // Direction sits at four times its index; the other registers share its window
    localparam logic [11:0] PRC_IDX_DIRECTION = 12'h282;
    localparam logic [11:0] PRC_OFF_DIRECTION = 12'(PRC_IDX_DIRECTION * 12'h004);
    localparam logic [11:0] PRC_OFF_DATA = 12'hA00;
    localparam logic [11:0] PRC_OFF_READBACK = 12'hA04;
    localparam logic [11:0] PRC_OFF_PULL_EN = 12'hA0C;
    localparam logic [11:0] PRC_OFF_PULL_POL = 12'hA10;
    localparam logic [11:0] PRC_OFF_OPEN_DRAIN = 12'hA14;
    localparam logic [11:0] PRC_OFF_IRQ_STATUS = 12'hA18;
    localparam logic [11:0] PRC_OFF_IRQ_MASK = 12'hA1C;
    localparam logic [11:0] PRC_OFF_OVERRIDE = 12'hA20;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] PRC_RST_DIRECTION = 8'h00;
    localparam logic [7:0] PRC_RST_DATA = 8'h00;
    localparam logic [7:0] PRC_RST_PULL_EN = 8'hFF;
    localparam logic [7:0] PRC_RST_PULL_POL = 8'h00;
    localparam logic [7:0] PRC_RST_OPEN_DRAIN = 8'h00;
    localparam logic [7:0] PRC_RST_MASK = 8'h00;
    // ****************************************
    // Bus responses and timing
    // ****************************************
    localparam logic [1:0] PRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PRC_RESP_SLVERR = 2'h2;
    localparam int PRC_SYNC_STAGES = 2;
    // Override flags in the override status register
    localparam int PRC_OVR_LCD = 0;
    localparam int PRC_OVR_TWB = 1;
    localparam int PRC_OVR_T1 = 2;
    localparam int PRC_OVR_T0 = 3;
    localparam int PRC_OVR_CTX = 4;
    localparam int PRC_OVR_CRX = 5;
endpackage

//--- design/prc_port_r.sv
// Port R pin control: registers, direction overrides, pad controls, edge flags.
// Assumes asynchronous pin levels at i_pin, synchronized in two stages, and peripheral enables from the chip.
`timescale 1ns/1ps
module prc_port_r #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    // AXI4-Lite slave
    input wire logic [prc_pkg::PRC_ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [prc_pkg::PRC_ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Peripheral alternate functions
    input wire logic i_lcd_seg_en,
    input wire logic i_twb_en,
    input wire logic [1:0] i_twb_out,
    input wire logic i_t1_oc_en,
    input wire logic [1:0] i_t1_out,
    input wire logic i_t0_oc_en,
    input wire logic [1:0] i_t0_out,
    input wire logic i_can_tx_en,
    input wire logic i_can_tx,
    input wire logic i_can_rx_en,
    // Pads
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_pin,
    output logic [WIDTH-1:0] o_pin_oe,
    output logic [WIDTH-1:0] o_in_buf_en,
    output logic [WIDTH-1:0] o_pull_on,
    output logic [WIDTH-1:0] o_pull_down,
    output logic [WIDTH-1:0] o_can_rx,
    output logic o_irq
);
    import prc_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [WIDTH-1:0] dir_reg, dir_next;
    logic [WIDTH-1:0] data_reg, data_next;
    logic [WIDTH-1:0] pull_en_reg, pull_en_next;
    logic [WIDTH-1:0] pull_pol_reg, pull_pol_next;
    logic [WIDTH-1:0] od_reg, od_next;
    logic [WIDTH-1:0] flag_reg, flag_next;
    logic [WIDTH-1:0] mask_reg, mask_next;
    logic [WIDTH-1:0] sync1_reg, sync2_reg, prev_reg;
    logic aw_got_reg, aw_got_next;
    logic w_got_reg, w_got_next;
    logic [PRC_ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic wr_fire;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [WIDTH-1:0] pin_next, oe_next, ibuf_next, pull_on_next, pull_dn_next;
    logic [WIDTH-1:0] eff_out, eff_in, eff_od, eff_val;
    logic [WIDTH-1:0] pin_o_reg, oe_reg, ibuf_reg, pull_on_reg, pull_dn_reg, rx_reg;
    logic irq_reg;

    // Known register address check, shared by read and write paths
    function automatic logic prc_known(input logic [PRC_ADDR_W-1:0] a);
        case (a)
            PRC_OFF_DATA, PRC_OFF_READBACK, PRC_OFF_DIRECTION, PRC_OFF_PULL_EN,
            PRC_OFF_PULL_POL, PRC_OFF_OPEN_DRAIN, PRC_OFF_IRQ_STATUS,
            PRC_OFF_IRQ_MASK, PRC_OFF_OVERRIDE: prc_known = 1'b1;
            default: prc_known = 1'b0;
        endcase
    endfunction

    // Byte-lane zero merge; only the low lane carries register bits
    function automatic logic [WIDTH-1:0] prc_merge(input logic [WIDTH-1:0] old,
                                                   input logic [31:0] d, input logic [3:0] s);
        prc_merge = s[0] ? d[WIDTH-1:0] : old;
    endfunction

    // ****************************************
    // Direction resolution and pad control
    // ****************************************
    // Peripheral overrides in priority order per pin; plain GPIO otherwise
    always_comb begin
        eff_out = dir_reg;
        eff_in = ~dir_reg;
        eff_od = od_reg;
        eff_val = data_reg;
        if (i_lcd_seg_en) begin
            eff_out[7] = 1'b0;
            eff_in[7] = 1'b0;
            eff_out[4] = 1'b0;
            eff_in[4] = 1'b0;
            eff_out[6] = 1'b0;
            eff_in[6] = 1'b0;
            eff_out[5] = 1'b0;
            eff_in[5] = 1'b0;
        end else if (i_twb_en) begin
            eff_out[6:5] = 2'h3;
            eff_in[6:5] = 2'h3; // Bus must also be sensed
            eff_od[6:5] = 2'h3;
            eff_val[6:5] = i_twb_out;
        end
        if (i_t1_oc_en) begin
            eff_out[3:2] = 2'h3;
            eff_in[3:2] = 2'h0;
            eff_val[3:2] = i_t1_out;
        end
        if (i_t0_oc_en) begin
            eff_out[1:0] = 2'h3;
            eff_in[1:0] = 2'h0;
            eff_val[1:0] = i_t0_out;
        end else begin
            if (i_can_tx_en) begin
                eff_out[1] = 1'b1;
                eff_in[1] = 1'b0;
                eff_val[1] = i_can_tx;
            end
            if (i_can_rx_en) begin
                eff_out[0] = 1'b0;
                eff_in[0] = 1'b1;
            end
        end
        // Open-drain: drive only zeros, release ones; inputs never driven
        for (int i = 0; i < WIDTH; i++) begin
            pin_next[i] = eff_od[i] ? 1'b0 : eff_val[i];
            oe_next[i] = eff_out[i] & ~(eff_od[i] & eff_val[i]);
        end
        ibuf_next = eff_in | eff_out; // Output pins still feed readback
        ibuf_next = ibuf_next & ~(i_lcd_seg_en ? 8'hF0 : 8'h00);
        pull_on_next = pull_en_reg & eff_in & ~eff_out;
        pull_dn_next = pull_pol_reg;
    end

    // Pad control flops so every output leaves a register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_o_reg <= '0;
            oe_reg <= '0;
            ibuf_reg <= '0;
            pull_on_reg <= '0;
            pull_dn_reg <= '0;
            rx_reg <= '0;
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            pin_o_reg <= pin_next;
            oe_reg <= oe_next;
            ibuf_reg <= ibuf_next;
            pull_on_reg <= pull_on_next;
            pull_dn_reg <= pull_dn_next;
            rx_reg <= {{(WIDTH-1){1'b0}}, sync2_reg[0]};
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // One write completes when both halves are held or arriving this cycle and no response waits.
    // Built from flops and inputs only, so the write path can use it without a loop.
    assign wr_fire = (aw_got_reg | i_awvalid) & (w_got_reg | i_wvalid) & ~bvalid_reg;

    // ****************************************
    // Edge flags and interrupt
    // ****************************************
    // Polarity picks rising or falling edge; a new edge wins over a clear
    always_comb begin
        logic [WIDTH-1:0] edge_hit;
        logic [WIDTH-1:0] clr;
        edge_hit = '0;
        clr = '0;
        for (int i = 0; i < WIDTH; i++) begin
            edge_hit[i] = pull_pol_reg[i] ? (sync2_reg[i] & ~prev_reg[i])
                                          : (~sync2_reg[i] & prev_reg[i]);
        end
        // Strobe and data are the write path's values: the live bus when W arrives this cycle, else the captured write
        if (wr_fire && awaddr_next == PRC_OFF_IRQ_STATUS && wstrb_next[0])
            clr = wdata_next[WIDTH-1:0];
        flag_next = (flag_reg & ~clr) | edge_hit;
    end

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    // Address and data captured in either order; response follows both
    // The lane strobe is captured with the data, since a master may drop it once W is taken
    always_comb begin
        aw_got_next = aw_got_reg | i_awvalid;
        w_got_next = w_got_reg | i_wvalid;
        awaddr_next = (i_awvalid & ~aw_got_reg) ? i_awaddr : awaddr_reg;
        wdata_next = (i_wvalid & ~w_got_reg) ? i_wdata : wdata_reg;
        wstrb_next = (i_wvalid & ~w_got_reg) ? i_wstrb : wstrb_reg;
        bvalid_next = bvalid_reg & ~i_bready;
        bresp_next = bresp_reg;
        dir_next = dir_reg;
        data_next = data_reg;
        pull_en_next = pull_en_reg;
        pull_pol_next = pull_pol_reg;
        od_next = od_reg;
        mask_next = mask_reg;
        if (bvalid_reg) begin
            aw_got_next = aw_got_reg;
            w_got_next = w_got_reg;
            awaddr_next = awaddr_reg;
            wdata_next = wdata_reg;
            wstrb_next = wstrb_reg;
        end else if (wr_fire) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = prc_known(awaddr_next) ? PRC_RESP_OKAY : PRC_RESP_SLVERR;
            case (awaddr_next)
                PRC_OFF_DIRECTION: dir_next = prc_merge(dir_reg, wdata_next, wstrb_next);
                PRC_OFF_DATA: data_next = prc_merge(data_reg, wdata_next, wstrb_next);
                PRC_OFF_PULL_EN: pull_en_next = prc_merge(pull_en_reg, wdata_next, wstrb_next);
                PRC_OFF_PULL_POL: pull_pol_next = prc_merge(pull_pol_reg, wdata_next, wstrb_next);
                PRC_OFF_OPEN_DRAIN: od_next = prc_merge(od_reg, wdata_next, wstrb_next);
                PRC_OFF_IRQ_MASK: mask_next = prc_merge(mask_reg, wdata_next, wstrb_next);
                default: ; // Readback, override: writes ignored; status writes clear flags in the edge-flag block
            endcase
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    // Reads answer one cycle after the address is taken
    always_comb begin
        rvalid_next = rvalid_reg & ~i_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (i_arvalid & ~rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = prc_known(i_araddr) ? PRC_RESP_OKAY : PRC_RESP_SLVERR;
            rdata_next = 32'h0000_0000;
            case (i_araddr)
                PRC_OFF_DATA: rdata_next[WIDTH-1:0] = (dir_reg & data_reg) | (~dir_reg & sync2_reg);
                PRC_OFF_READBACK: rdata_next[WIDTH-1:0] = sync2_reg;
                PRC_OFF_DIRECTION: rdata_next[WIDTH-1:0] = dir_reg;
                PRC_OFF_PULL_EN: rdata_next[WIDTH-1:0] = pull_en_reg;
                PRC_OFF_PULL_POL: rdata_next[WIDTH-1:0] = pull_pol_reg;
                PRC_OFF_OPEN_DRAIN: rdata_next[WIDTH-1:0] = od_reg;
                PRC_OFF_IRQ_STATUS: rdata_next[WIDTH-1:0] = flag_reg;
                PRC_OFF_IRQ_MASK: rdata_next[WIDTH-1:0] = mask_reg;
                PRC_OFF_OVERRIDE: rdata_next[5:0] = {i_can_rx_en, i_can_tx_en, i_t0_oc_en,
                                                     i_t1_oc_en, i_twb_en, i_lcd_seg_en};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Register bank; software-visible state takes documented resets
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            dir_reg <= PRC_RST_DIRECTION;
            data_reg <= PRC_RST_DATA;
            pull_en_reg <= PRC_RST_PULL_EN;
            pull_pol_reg <= PRC_RST_PULL_POL;
            od_reg <= PRC_RST_OPEN_DRAIN;
            mask_reg <= PRC_RST_MASK;
            flag_reg <= '0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= PRC_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= PRC_RESP_OKAY;
            irq_reg <= 1'b0;
        end else begin
            dir_reg <= dir_next;
            data_reg <= data_next;
            pull_en_reg <= pull_en_next;
            pull_pol_reg <= pull_pol_next;
            od_reg <= od_next;
            mask_reg <= mask_next;
            flag_reg <= flag_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            irq_reg <= |(flag_next & mask_next);
        end
    end

    // Output assignments, all from flops
    assign o_awready = ~aw_got_reg & ~bvalid_reg;
    assign o_wready = ~w_got_reg & ~bvalid_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_arready = ~rvalid_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_pin = pin_o_reg;
    assign o_pin_oe = oe_reg;
    assign o_in_buf_en = ibuf_reg;
    assign o_pull_on = pull_on_reg;
    assign o_pull_down = pull_dn_reg;
    assign o_can_rx = rx_reg;
    assign o_irq = irq_reg;
endmodule // prc_port_r

//--- testbench/prc_port_r_chk.sv
// Checker for prc_port_r: pad overrides, pull gating, bus response hold.
// Assumes it is bound onto prc_port_r and sees only its ports.
`timescale 1ns/1ps
module prc_port_r_chk #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_bready,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic i_lcd_seg_en,
    input wire logic i_twb_en,
    input wire logic [1:0] i_twb_out,
    input wire logic i_t1_oc_en,
    input wire logic [1:0] i_t1_out,
    input wire logic i_t0_oc_en,
    input wire logic [1:0] i_t0_out,
    input wire logic i_can_tx_en,
    input wire logic i_can_tx,
    input wire logic i_can_rx_en,
    input wire logic [WIDTH-1:0] o_pin,
    input wire logic [WIDTH-1:0] o_pin_oe,
    input wire logic [WIDTH-1:0] o_in_buf_en,
    input wire logic [WIDTH-1:0] o_pull_on
);
    // ****************************************
    // Properties, all in the one clock domain
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_lcd; i_lcd_seg_en |=> !o_pin_oe[7] && !o_pin_oe[4] && !o_in_buf_en[7] && !o_in_buf_en[4]; endproperty
    a_lcd: assert property (p_lcd) else $error("lcd pins still buffered");
    property p_twb; !i_lcd_seg_en && i_twb_en |=> o_pin_oe[6] == !$past(i_twb_out[1]); endproperty
    a_twb: assert property (p_twb) else $error("two-wire pin not open-drain");
    // Pad level as seen on the wire: a released open-drain bit reads as high
    property p_t1; i_t1_oc_en |=> (o_pin[3:2] | ~o_pin_oe[3:2]) == $past(i_t1_out) && o_pull_on[3:2] == 2'h0;
    endproperty
    a_t1: assert property (p_t1) else $error("timer one pins not forced");
    property p_t0; i_t0_oc_en |=> (o_pin[1:0] | ~o_pin_oe[1:0]) == $past(i_t0_out) && o_pull_on[1:0] == 2'h0;
    endproperty
    a_t0: assert property (p_t0) else $error("timer zero pin not forced");
    property p_ctx; !i_t0_oc_en && i_can_tx_en |=> (o_pin[1] | ~o_pin_oe[1]) == $past(i_can_tx); endproperty
    a_ctx: assert property (p_ctx) else $error("transmit pin not forced");
    property p_crx; !i_t0_oc_en && i_can_rx_en |=> !o_pin_oe[0] && o_in_buf_en[0]; endproperty
    a_crx: assert property (p_crx) else $error("receive pin not input");
    property p_pull; (o_pull_on & o_pin_oe) == '0; endproperty
    a_pull: assert property (p_pull) else $error("pull on a driven pin");
    property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule // prc_port_r_chk
bind prc_port_r prc_port_r_chk #(.WIDTH(WIDTH)) u_chk (.*);

//--- testbench/prc_pin_model.sv
// Pad model for port R: wire level from block drive, bench drive and pulls.
// Assumes the block's own drive beats the bench drive.
`timescale 1ns/1ps
module prc_pin_model (
    input wire logic i_clk,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_pull_on,
    input wire logic [7:0] i_pull_down,
    input wire logic i_ext_en,
    input wire logic [7:0] i_ext,
    output logic [7:0] o_level
);
    logic [7:0] float_reg = 8'h55;
    // Floating pins change every cycle so a stale level never passes
    always_ff @(posedge i_clk) begin
        float_reg <= ~float_reg;
    end
    // Per-pin wire resolution
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_oe[i]) o_level[i] = i_out[i];
            else if (i_ext_en) o_level[i] = i_ext[i];
            else if (i_pull_on[i]) o_level[i] = ~i_pull_down[i];
            else o_level[i] = float_reg[i];
        end
    end
endmodule // prc_pin_model

//--- testbench/prc_port_r_tb.sv
// Testbench for prc_port_r: AXI4-Lite register tests, pad and override checks.
// Assumes prc_pkg, the pin model and the bound checker; 10 MHz clock.
`timescale 1ns/1ps
module prc_port_r_tb;
    import prc_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [5:0] ovr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ext_en = 1;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] oc_out = 0, bresp, rresp, last_resp;
    logic [7:0] ext = 0, pin, pout, poe, ibe, pon, pdn, crx;
    logic awready, wready, bvalid, arready, rvalid, irq;
    int error_cnt = 0, compares = 0;
    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end
    prc_port_r dut (.i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_lcd_seg_en(ovr[0]), .i_twb_en(ovr[1]),
        .i_twb_out(oc_out), .i_t1_oc_en(ovr[2]), .i_t1_out(oc_out), .i_t0_oc_en(ovr[3]), .i_t0_out(oc_out),
        .i_can_tx_en(ovr[4]), .i_can_tx(oc_out[0]), .i_can_rx_en(ovr[5]), .i_pin(pin), .o_pin(pout),
        .o_pin_oe(poe), .o_in_buf_en(ibe), .o_pull_on(pon), .o_pull_down(pdn), .o_can_rx(crx), .o_irq(irq));
    prc_pin_model pads (.i_clk(clk), .i_out(pout), .i_oe(poe), .i_pull_on(pon), .i_pull_down(pdn),
        .i_ext_en(ext_en), .i_ext(ext), .o_level(pin));
    // ****************************************
    // Bus tasks and compares
    // ****************************************
    task automatic finish_test();
        $display("mismatches %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Readies are sampled 1 ns after an edge, when they are settled for the next one
    // Bready rises one cycle after bvalid is seen, so the response hold is exercised
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        logic ta, tw, tb, done;
        n = 0;
        done = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        while (!done && n < 40) begin
            #1;
            ta = awready;
            tw = wready;
            tb = bvalid;
            last_resp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            done = tb & bready;
            if (tb & !done) bready <= 1;
            n++;
        end
        if (done) begin
            bready <= 0;
        end else begin
            chk("write timeout", 1, 0);
            finish_test();
        end
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] e);
        int n;
        logic ta, tr;
        logic [31:0] d;
        n = 0;
        tr = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!tr && n < 40) begin
            #1;
            ta = arready;
            tr = rvalid;
            d = rdata;
            last_resp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 0;
            n++;
        end
        rready <= 0;
        if (!tr) begin
            chk("read timeout", 1, 0);
            finish_test();
        end
        chk(nm, {24'h0, e}, d);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rdc("direction", PRC_OFF_DIRECTION, 8'h00);
        rdc("pull enable", PRC_OFF_PULL_EN, 8'hFF);
        rdc("polarity", PRC_OFF_PULL_POL, 8'h00);
        rdc("open drain", PRC_OFF_OPEN_DRAIN, 8'h00);
        rdc("unmapped", 12'hA3C, 8'h00);
        chk("unmapped resp", {30'h0, PRC_RESP_SLVERR}, {30'h0, last_resp});
        wr(12'hA3C, 8'h11);
        chk("unmapped wr resp", {30'h0, PRC_RESP_SLVERR}, {30'h0, last_resp});
        $display("test reset done");
        ext <= 8'hA5;
        settle(4);
        chk("pull in", 32'hFF, {24'h0, pon});
        rdc("readback in", PRC_OFF_READBACK, 8'hA5);
        rdc("data in", PRC_OFF_DATA, 8'hA5);
        wr(PRC_OFF_READBACK, 8'h5A);
        chk("ro wr resp", {30'h0, PRC_RESP_OKAY}, {30'h0, last_resp});
        rdc("readback ro", PRC_OFF_READBACK, 8'hA5);
        $display("test input done");
        wr(PRC_OFF_DATA, 8'h3C);
        wr(PRC_OFF_DIRECTION, 8'hFF);
        settle(3);
        chk("oe out", 32'hFF, {24'h0, poe});
        chk("pull out", 32'h00, {24'h0, pon});
        rdc("readback out", PRC_OFF_READBACK, 8'h3C);
        rdc("data out", PRC_OFF_DATA, 8'h3C);
        wr(PRC_OFF_DATA, 8'h0F);
        wr(PRC_OFF_OPEN_DRAIN, 8'hFF);
        settle(2);
        chk("oe drain", 32'hF0, {24'h0, poe});
        wr(PRC_OFF_DIRECTION, 8'h00);
        settle(2);
        chk("oe drain in", 32'h00, {24'h0, poe});
        $display("test output done");
        ext_en <= 0;
        wr(PRC_OFF_PULL_POL, 8'hF0);
        settle(4);
        chk("pull down", 32'hF0, {24'h0, pdn});
        rdc("pulled", PRC_OFF_READBACK, 8'h0F);
        ext_en <= 1;
        ext <= 8'h00;
        wr(PRC_OFF_PULL_POL, 8'h01);
        wr(PRC_OFF_IRQ_MASK, 8'h01);
        settle(4);
        wr(PRC_OFF_IRQ_STATUS, 8'hFF);
        rdc("status clr", PRC_OFF_IRQ_STATUS, 8'h00);
        ext <= 8'h01;
        settle(5);
        rdc("status rise", PRC_OFF_IRQ_STATUS, 8'h01);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(PRC_OFF_IRQ_MASK, 8'h00);
        settle(2);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(PRC_OFF_IRQ_MASK, 8'h01);
        wr(PRC_OFF_IRQ_STATUS, 8'h01);
        settle(2);
        chk("irq clr", 32'h0, {31'h0, irq});
        $display("test edge flag done");
        for (int k = 0; k < 6; k++) begin
            ovr <= 6'(1 << k);
            oc_out <= 2'(k);
            settle(3);
            rdc("override", PRC_OFF_OVERRIDE, 8'(1 << k));
        end
        chk("can rx", 32'h01, {24'h0, crx});
        ovr <= 6'h00;
        $display("test override done");
        finish_test();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        chk("watchdog", 0, 1);
        finish_test();
    end
endmodule // prc_port_r_tb
